// ===== sim/analog_front_model.sv
// behavioural analog comparator inputs and reference source
// assumes the bench sets input and reference levels as 8-bit codes
`timescale 1ns/100ps
`default_nettype none
module analog_front_model (
  input wire logic clk_sys,
  input wire logic comparing,
  input wire logic ref_external,
  input wire logic [7:0] vin_0,
  input wire logic [7:0] vin_1,
  input wire logic [7:0] vref_int,
  input wire logic [7:0] vref_ext,
  output logic above_0,
  output logic above_1
);
  logic idle_toggle = 1'b0;
  logic [7:0] vref;
  always @(posedge clk_sys) begin
    idle_toggle <= ~idle_toggle;
  end
  assign vref = ref_external ? vref_ext : vref_int;
  // no stable level outside a compare
  assign above_0 = comparing ? (vin_0 > vref) : idle_toggle;
  assign above_1 = comparing ? (vin_1 > vref) : ~idle_toggle;
endmodule : analog_front_model
`default_nettype wire

// ===== sim/voltage_comparator_control_test.sv
// self-checking bench of the comparator control
// assumes the analog front model on the comparator inputs
`timescale 1ns/100ps
`default_nettype none
`include "voltage_comparator_defs.svh"
module voltage_comparator_control_test;
  logic clk_sys, rst_n, active_mode, wr_en, test_req, above_0, above_1;
  logic test_valid, processor_test_flag, comparing, ref_external;
  logic port_a_enable, port_b_enable, port_c_enable;
  logic [9:0] wr_addr, test_addr;
  logic [3:0] wr_data;
  logic [1:0] test_bit;
  logic [7:0] vin_0, vin_1;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  voltage_comparator_control voltage_comparator_control_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .active_mode(active_mode), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .test_req(test_req), .test_addr(test_addr), .test_bit(test_bit),
    .analog_above_0(above_0), .analog_above_1(above_1), .test_valid(test_valid),
    .processor_test_flag(processor_test_flag), .comparing(comparing),
    .ref_external(ref_external), .port_a_enable(port_a_enable),
    .port_b_enable(port_b_enable), .port_c_enable(port_c_enable));
  analog_front_model analog_front_model_inst (.clk_sys(clk_sys), .comparing(comparing),
    .ref_external(ref_external), .vin_0(vin_0), .vin_1(vin_1), .vref_int(8'h80),
    .vref_ext(8'hF0), .above_0(above_0), .above_1(above_1));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cycles
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic write_reg(input logic [9:0] a, input logic [3:0] d);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    cycles(1);
    wr_en = 1'b0;
    cycles(2);
  endtask : write_reg
  task automatic probe(input logic [9:0] a, input logic [1:0] b, input logic [1:0] exp);
    test_req = 1'b1;
    test_addr = a;
    test_bit = b;
    cycles(1);
    check({2'h0, test_valid, processor_test_flag}, {2'h0, exp});
    test_req = 1'b0;
    cycles(1);
  endtask : probe
  task automatic pins(input logic [3:0] exp);
    check({port_a_enable, port_b_enable, port_c_enable, comparing}, exp);
  endtask : pins
  task automatic complete_run;
    $display("checks=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    rst_n = 1'b0;
    active_mode = 1'b1;
    wr_en = 1'b0;
    test_req = 1'b0;
    wr_addr = 10'h000;
    test_addr = 10'h000;
    wr_data = 4'h0;
    test_bit = 2'h0;
    vin_0 = 8'hC0;
    vin_1 = 8'h10;
    cycles(12);
    rst_n = 1'b1;
    pins(4'hE);
    write_reg(`CMP_CTRL_ADDR, 4'hB);
    pins(4'h3);
    probe(`CMP_RESULT_ADDR, 2'h0, 2'h3);
    probe(`CMP_RESULT_ADDR, 2'h1, 2'h2);
    vin_0 = 8'h10;
    vin_1 = 8'hC0;
    cycles(2);
    probe(`CMP_RESULT_ADDR, 2'h0, 2'h2);
    probe(`CMP_RESULT_ADDR, 2'h1, 2'h3);
    probe(`CMP_RESULT_ADDR, 2'h2, 2'h1);
    probe(`CMP_CTRL_ADDR, 2'h1, 2'h1);
    write_reg(`CMP_RESULT_ADDR, 4'h0);
    pins(4'h3);
    write_reg(`CMP_CTRL_ADDR, 4'h9);
    probe(`CMP_RESULT_ADDR, 2'h1, 2'h2);
    write_reg(`CMP_CTRL_ADDR, 4'hF);
    pins(4'h1);
    check({3'h0, ref_external}, 4'h1);
    probe(`CMP_RESULT_ADDR, 2'h1, 2'h2);
    active_mode = 1'b0;
    cycles(2);
    pins(4'hC);
    probe(`CMP_RESULT_ADDR, 2'h0, 2'h2);
    active_mode = 1'b1;
    cycles(2);
    pins(4'h1);
    write_reg(`CMP_CTRL_ADDR, 4'h3);
    pins(4'hE);
    probe(`CMP_RESULT_ADDR, 2'h1, 2'h2);
    complete_run();
  end
endmodule : voltage_comparator_control_test
`default_nettype wire

// ===== verilog/comparator_result_store.sv
// two-bit result latch of the comparator
// assumes capture and clear come from the compare sequencer
`timescale 1ns/100ps
`default_nettype none
`include "voltage_comparator_defs.svh"

module comparator_result_store (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic capture,
  input wire voltage_comparator_pkg::result_t sample,
  output voltage_comparator_pkg::result_t result
);

  voltage_comparator_pkg::result_t next_result;

  // ----------------------------------------------------------------------
  // per-bit latch
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_bit
      always_comb begin
        next_result[gi] = capture ? sample[gi] : 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      result <= `CMP_RESULT_RESET;
    end else begin
      result <= next_result;
    end
  end

endmodule : comparator_result_store
`default_nettype wire

// ===== verilog/voltage_comparator_control.sv
// comparator control: write-only control register, bit-test read path
// assumes the core gives one-cycle write and bit-test strobes
`timescale 1ns/100ps
`default_nettype none
`include "voltage_comparator_defs.svh"

// Function
// - writing one to bit 3 starts comparing
// - input above reference, bit test sets flag
// - input below reference, bit test clears flag
// - control register write-only: enable, reference, input
// - select bits 0 and 1 choose input
// - two-bit read-only result latch
// - result bit 0 input 0, bit 1 input 1
// - results readable only by bit test
// - results lost once comparing ends
// - shared pins analog while comparing
// - comparator works only in active mode
// - external reference frees reference pin from port
module voltage_comparator_control (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic active_mode,
  input wire logic wr_en,
  input wire logic [9:0] wr_addr,
  input wire logic [3:0] wr_data,
  input wire logic test_req,
  input wire logic [9:0] test_addr,
  input wire logic [1:0] test_bit,
  input wire logic analog_above_0,
  input wire logic analog_above_1,
  output logic test_valid,
  output logic processor_test_flag,
  output logic comparing,
  output logic ref_external,
  output logic port_a_enable,
  output logic port_b_enable,
  output logic port_c_enable
);

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  logic compare_go_bit;
  logic input_select_bit0;
  logic input_select_bit1;
  logic next_go;
  logic next_ref_ext;
  logic next_sel0;
  logic next_sel1;
  logic ctrl_wr;

  always_comb begin
    ctrl_wr = wr_en && (wr_addr == `CMP_CTRL_ADDR);
    next_go = compare_go_bit;
    next_ref_ext = ref_external;
    next_sel0 = input_select_bit0;
    next_sel1 = input_select_bit1;
    if (ctrl_wr) begin
      next_go = wr_data[`CMP_GO_BIT];
      next_ref_ext = wr_data[`CMP_REF_EXT_BIT];
      next_sel0 = wr_data[`CMP_SEL0_BIT];
      next_sel1 = wr_data[`CMP_SEL1_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      compare_go_bit <= `CMP_GO_RESET;
      ref_external <= `CMP_REF_EXT_RESET;
      {input_select_bit1, input_select_bit0} <= `CMP_SEL_RESET;
    end else begin
      compare_go_bit <= next_go;
      ref_external <= next_ref_ext;
      input_select_bit0 <= next_sel0;
      input_select_bit1 <= next_sel1;
    end
  end

  // ----------------------------------------------------------------------
  // compare sequencer
  // ----------------------------------------------------------------------
  voltage_comparator_pkg::cmp_state_e state;
  voltage_comparator_pkg::cmp_state_e next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      voltage_comparator_pkg::S_IDLE: begin
        if (compare_go_bit && active_mode) begin
          next_state = voltage_comparator_pkg::S_CMP;
        end
      end
      voltage_comparator_pkg::S_CMP: begin
        if (!compare_go_bit || !active_mode) begin
          next_state = voltage_comparator_pkg::S_IDLE;
        end
      end
      default: begin
        next_state = voltage_comparator_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= voltage_comparator_pkg::S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign comparing = (state == voltage_comparator_pkg::S_CMP);

  // ----------------------------------------------------------------------
  // pin function
  // ----------------------------------------------------------------------
  assign port_a_enable = !comparing;
  assign port_b_enable = !comparing;
  assign port_c_enable = !ref_external;

  // ----------------------------------------------------------------------
  // result latch
  // ----------------------------------------------------------------------
  voltage_comparator_pkg::result_t sample;
  voltage_comparator_pkg::result_t result;

  always_comb begin
    sample[0] = analog_above_0 && input_select_bit0;
    sample[1] = analog_above_1 && input_select_bit1;
  end

  comparator_result_store u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .capture(comparing),
    .sample(sample),
    .result(result)
  );

  // ----------------------------------------------------------------------
  // bit-test read path
  // ----------------------------------------------------------------------
  logic test_hit;
  logic next_test_valid;
  logic next_test_flag;

  always_comb begin
    test_hit = test_req && (test_addr == `CMP_RESULT_ADDR) && !test_bit[1];
    next_test_valid = test_hit;
    next_test_flag = processor_test_flag;
    if (test_hit) begin
      next_test_flag = result[test_bit[0]];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      test_valid <= 1'b0;
      processor_test_flag <= 1'b0;
    end else begin
      test_valid <= next_test_valid;
      processor_test_flag <= next_test_flag;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_go_write;
    ctrl_wr && wr_data[3] && active_mode ##1 (active_mode && !ctrl_wr);
  endsequence

  property p_go_starts;
    @(posedge clk_sys) disable iff (!rst_n) s_go_write |=> comparing;
  endproperty
  a_go_starts: assert property (p_go_starts) else $error("compare did not start");

  property p_flag_high;
    @(posedge clk_sys) disable iff (!rst_n)
      test_hit && result[test_bit[0]] |=> test_valid && processor_test_flag;
  endproperty
  a_flag_high: assert property (p_flag_high) else $error("flag not set");

  property p_flag_low;
    @(posedge clk_sys) disable iff (!rst_n)
      test_hit && !result[test_bit[0]] |=> test_valid && !processor_test_flag;
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("flag not cleared");

  property p_unselected;
    @(posedge clk_sys) disable iff (!rst_n) !input_select_bit0 |=> !result[0];
  endproperty
  a_unselected: assert property (p_unselected) else $error("unselected input latched");

  property p_latch_one;
    @(posedge clk_sys) disable iff (!rst_n)
      comparing && input_select_bit1 && analog_above_1 |=> result[1];
  endproperty
  a_latch_one: assert property (p_latch_one) else $error("input 1 not latched");

  property p_not_kept;
    @(posedge clk_sys) disable iff (!rst_n) !comparing |=> result == 2'h0;
  endproperty
  a_not_kept: assert property (p_not_kept) else $error("result kept after compare");

  property p_pins_analog;
    @(posedge clk_sys) disable iff (!rst_n)
      compare_go_bit && active_mode |=> comparing && !port_a_enable && !port_b_enable;
  endproperty
  a_pins_analog: assert property (p_pins_analog) else $error("port active in compare");

  property p_active_only;
    @(posedge clk_sys) disable iff (!rst_n) !active_mode |=> !comparing;
  endproperty
  a_active_only: assert property (p_active_only) else $error("compare outside active");

  property p_ref_pin;
    @(posedge clk_sys) disable iff (!rst_n)
      ctrl_wr && wr_data[2] |=> !port_c_enable;
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference pin still port");

  property p_read_only_test;
    @(posedge clk_sys) disable iff (!rst_n)
      !(test_req && (test_addr == `CMP_RESULT_ADDR) && !test_bit[1])
        |=> !test_valid && $stable(processor_test_flag);
  endproperty
  a_read_only_test: assert property (p_read_only_test) else $error("stray result read");

endmodule : voltage_comparator_control
`default_nettype wire

// ===== verilog/voltage_comparator_defs.svh
// offsets, field positions and reset values of the comparator control
// assumes a 10-bit data-memory address space of the 4-bit core
`ifndef VOLTAGE_COMPARATOR_DEFS_SVH
`define VOLTAGE_COMPARATOR_DEFS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define CMP_ADDR_W 10
`define CMP_RESULT_ADDR 10'h017
`define CMP_CTRL_ADDR 10'h018

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CMP_GO_BIT 3
`define CMP_REF_EXT_BIT 2
`define CMP_SEL0_BIT 0
`define CMP_SEL1_BIT 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CMP_GO_RESET 1'h0
`define CMP_REF_EXT_RESET 1'h0
`define CMP_SEL_RESET 2'h0
`define CMP_RESULT_RESET 2'h0

`endif

// ===== verilog/voltage_comparator_pkg.sv
// types shared by the comparator control files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package voltage_comparator_pkg;

  // ----------------------------------------------------------------------
  // compare sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'h1,
    S_CMP = 2'h2
  } cmp_state_e;

  typedef logic [1:0] result_t;

endpackage : voltage_comparator_pkg
`default_nettype wire
